// *** src/idle_error_counter.v ***
// saturating event counter that clears on a read strobe
// assumes the event input is already in the mclk domain
`timescale 1ns/100ps
`default_nettype none
module idle_error_counter #(
  parameter WIDTH = 8
) (
  input wire mclk,
  input wire sys_rst,
  input wire count_event,
  input wire clear_read,
  output reg [WIDTH-1:0] count_reg
);
  reg [WIDTH-1:0] count_next;
  always @* begin
    count_next = count_reg;
    // a read restarts counting; an event in the read cycle counts as one
    if (clear_read) begin
      count_next = {{(WIDTH-1){1'b0}}, count_event};
    end else if (count_event && (count_reg != {WIDTH{1'b1}})) begin
      count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
  always @(posedge mclk) begin
    if (sys_rst) begin
      count_reg <= {WIDTH{1'b0}};
    end else begin
      count_reg <= count_next;
    end
  end
endmodule
`default_nettype wire

// *** src/phy_mgmt_map.vh ***
// register offsets, field positions and fixed values of the management slice
// assumes a 5-bit register address from the management frame decoder
`ifndef PHY_MGMT_MAP_VH
`define PHY_MGMT_MAP_VH
`define GIG_LINK_STATUS_ADDR 5'h0A
`define INDIRECT_CTRL_ADDR 5'h0D
`define INDIRECT_ADDR_DATA_ADDR 5'h0E
`define GIG_CAPABILITY_ADDR 5'h0F
`define GLS_FAULT_BIT 15
`define GLS_MASTER_BIT 14
`define GLS_LOCAL_RX_BIT 13
`define GLS_REMOTE_RX_BIT 12
`define GLS_LP_FULL_BIT 11
`define GLS_LP_HALF_BIT 10
`define FUNC_HI 15
`define FUNC_LO 14
`define DEVSEL_HI 4
`define DEVSEL_LO 0
`define FUNC_ADDRESS 2'h0
`define FUNC_DATA_NOINC 2'h1
`define FUNC_DATA_INC_RW 2'h2
`define FUNC_DATA_INC_WR 2'h3
`define MMD_DEVICE_VALUE 5'h1F
`define CAPABILITY_VALUE 16'h3000
`define IDLE_COUNT_MAX 8'hFF
`define IDLE_COUNT_HI 7
`define IDLE_COUNT_LO 0
`define PTR_STEP 16'h0001
`define ZERO16 16'h0000
`define ZERO8 8'h00
`define ZERO5 5'h00
`define ZERO2 2'h0
`endif

// *** src/phy_status_and_indirect_access_regs.v ***
// gigabit status, indirect extended-register access pair and capability register
// assumes a management frame decoder on mclk giving one-cycle read and write strobes;
// the extended register array lives outside and answers reads in the same cycle
//
// Contract
// RQ1 - status bit 15 latches a manual master/slave fault until the register is read
// RQ2 - status bit 14 shows resolution: one master, zero slave
// RQ3 - bits 13 and 12 show local and remote receiver OK
// RQ4 - bits 11 and 10 show partner 1000BASE-T full and half ability, reset zero
// RQ5 - status bits 9:8 and capability bits 11:0 read zero, ignore writes
// RQ6 - status bits 7:0 count idle errors, reset zero, cleared on read
// RQ7 - idle error count saturates at its maximum
// RQ8 - function 00: data register write loads the extended address pointer
// RQ9 - function 01: data register accesses pointed register, pointer unchanged
// RQ10 - function 10: pointer increments after every read or write access
// RQ11 - function 11: pointer increments after writes only
// RQ12 - extended registers reached only through control 0x0D and address/data 0x0E
// RQ13 - indirect access takes effect only with device select 11111
// RQ14 - host writes 0x1F device select with the function code first
// RQ15 - host loads the pointer with function 00 before data accesses
// RQ16 - control bits 13:5 read zero; function and device select reset zero
// RQ17 - address/data is the pointer in function 00, else the data window
// RQ18 - capability register fixed: bits 13,12 one, 15,14 zero
// RQ19 - fault and resolution relate to the manual master/slave enable setting
`timescale 1ns/100ps
`default_nettype none
`include "phy_mgmt_map.vh"
module phy_status_and_indirect_access_regs #(
  parameter IDLE_COUNT_WIDTH = 8
) (
  input wire mclk,
  input wire sys_rst,
  input wire [4:0] reg_addr,
  input wire reg_read,
  input wire reg_write,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  output reg reg_rvalid,
  input wire ms_fault_pin,
  input wire ms_master_pin,
  input wire local_rx_ok_pin,
  input wire remote_rx_ok_pin,
  input wire lp_full_pin,
  input wire lp_half_pin,
  input wire idle_error_pin,
  output reg [15:0] ext_addr,
  output reg [15:0] ext_wdata,
  output reg ext_write,
  output reg ext_read,
  input wire [15:0] ext_rdata
);
  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  // status comes from the link logic on other clocks, so two stages per bit;
  // only the second stage is read, the first may still be settling
  localparam SYNC_WIDTH = 7;
  localparam SYNC_FAULT = 0;
  localparam SYNC_MASTER = 1;
  localparam SYNC_LOCAL_RX = 2;
  localparam SYNC_REMOTE_RX = 3;
  localparam SYNC_LP_FULL = 4;
  localparam SYNC_LP_HALF = 5;
  localparam SYNC_IDLE = 6;
  wire [SYNC_WIDTH-1:0] pin_bus;
  wire [SYNC_WIDTH-1:0] sync_bus;
  assign pin_bus[SYNC_FAULT] = ms_fault_pin;
  assign pin_bus[SYNC_MASTER] = ms_master_pin;
  assign pin_bus[SYNC_LOCAL_RX] = local_rx_ok_pin;
  assign pin_bus[SYNC_REMOTE_RX] = remote_rx_ok_pin;
  assign pin_bus[SYNC_LP_FULL] = lp_full_pin;
  assign pin_bus[SYNC_LP_HALF] = lp_half_pin;
  assign pin_bus[SYNC_IDLE] = idle_error_pin;
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_WIDTH; gi = gi + 1) begin : g_sync
      reg stage1_reg;
      reg stage2_reg;
      always @(posedge mclk) begin
        if (sys_rst) begin
          stage1_reg <= 1'b0;
          stage2_reg <= 1'b0;
        end else begin
          stage1_reg <= pin_bus[gi];
          stage2_reg <= stage1_reg;
        end
      end
      assign sync_bus[gi] = stage2_reg;
    end
  endgenerate

  // ****************************************************************
  // idle error edge detect
  // ****************************************************************
  // the previous level resets low like the idle synchroniser stages, so reset gives no false edge
  reg idle_prev_reg;
  always @(posedge mclk) begin
    if (sys_rst) begin
      idle_prev_reg <= 1'b0;
    end else begin
      idle_prev_reg <= sync_bus[SYNC_IDLE];
    end
  end
  wire fault_s = sync_bus[SYNC_FAULT];
  wire idle_event = sync_bus[SYNC_IDLE] & ~idle_prev_reg;

  // ****************************************************************
  // decode
  // ****************************************************************
  wire sel_status = (reg_addr == `GIG_LINK_STATUS_ADDR);
  wire sel_ctrl = (reg_addr == `INDIRECT_CTRL_ADDR);
  wire sel_data = (reg_addr == `INDIRECT_ADDR_DATA_ADDR);
  wire sel_cap = (reg_addr == `GIG_CAPABILITY_ADDR);
  wire status_read = reg_read & sel_status;

  // ****************************************************************
  // gigabit link status
  // ****************************************************************
  reg fault_reg;
  reg fault_next;
  always @* begin
    fault_next = fault_reg;
    if (status_read) begin
      fault_next = 1'b0;
    end
    // the detection wins over the clearing read so no fault is lost [RQ1] [RQ19]
    if (fault_s) begin
      fault_next = 1'b1;
    end
  end
  always @(posedge mclk) begin
    if (sys_rst) begin
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= fault_next; // [RQ1]
    end
  end

  // ****************************************************************
  // idle error counter
  // ****************************************************************
  wire [IDLE_COUNT_WIDTH-1:0] idle_count;
  idle_error_counter #(
    .WIDTH(IDLE_COUNT_WIDTH)
  ) u_idle_count (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .count_event(idle_event), // saturating count [RQ6] [RQ7]
    .clear_read(status_read),
    .count_reg(idle_count)
  );

  // ****************************************************************
  // status word
  // ****************************************************************
  // reserved bits keep the zero of the default and have no storage [RQ5]
  reg [15:0] status_value;
  always @* begin
    status_value = `ZERO16;
    status_value[`GLS_FAULT_BIT] = fault_reg; // [RQ1]
    status_value[`GLS_MASTER_BIT] = sync_bus[SYNC_MASTER]; // [RQ2] [RQ19]
    status_value[`GLS_LOCAL_RX_BIT] = sync_bus[SYNC_LOCAL_RX]; // [RQ3]
    status_value[`GLS_REMOTE_RX_BIT] = sync_bus[SYNC_REMOTE_RX]; // [RQ3]
    status_value[`GLS_LP_FULL_BIT] = sync_bus[SYNC_LP_FULL]; // [RQ4]
    status_value[`GLS_LP_HALF_BIT] = sync_bus[SYNC_LP_HALF]; // [RQ4]
    status_value[`IDLE_COUNT_HI:`IDLE_COUNT_LO] = idle_count[`IDLE_COUNT_HI-`IDLE_COUNT_LO:0]; // [RQ6]
  end

  // ****************************************************************
  // indirect access control and pointer
  // ****************************************************************
  reg [1:0] func_reg;
  reg [4:0] devsel_reg;
  reg [15:0] pointer_reg;
  reg [15:0] pointer_next;
  wire dev_ok = (devsel_reg == `MMD_DEVICE_VALUE); // [RQ13] [RQ14]
  wire data_mode = (func_reg != `FUNC_ADDRESS);
  wire data_wr = reg_write & sel_data & dev_ok;
  wire data_rd = reg_read & sel_data & dev_ok;

  reg [1:0] func_next;
  reg [4:0] devsel_next;
  always @* begin
    func_next = func_reg;
    devsel_next = devsel_reg;
    // bits 13:5 have no storage, so they read back zero [RQ16]
    if (reg_write && sel_ctrl) begin
      func_next = reg_wdata[`FUNC_HI:`FUNC_LO];
      devsel_next = reg_wdata[`DEVSEL_HI:`DEVSEL_LO];
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      func_reg <= `ZERO2; // [RQ16]
      devsel_reg <= `ZERO5;
    end else begin
      func_reg <= func_next;
      devsel_reg <= devsel_next;
    end
  end

  always @* begin
    pointer_next = pointer_reg;
    case (func_reg)
      `FUNC_ADDRESS: begin
        if (data_wr) begin
          pointer_next = reg_wdata; // [RQ8] [RQ15]
        end
      end
      `FUNC_DATA_NOINC: begin
        pointer_next = pointer_reg; // [RQ9]
      end
      `FUNC_DATA_INC_RW: begin
        if (data_wr || data_rd) begin
          pointer_next = pointer_reg + `PTR_STEP; // [RQ10]
        end
      end
      `FUNC_DATA_INC_WR: begin
        if (data_wr) begin
          pointer_next = pointer_reg + `PTR_STEP; // [RQ11]
        end
      end
      default: begin
        pointer_next = pointer_reg;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      pointer_reg <= `ZERO16;
    end else begin
      pointer_reg <= pointer_next;
    end
  end

  // ****************************************************************
  // extended register port
  // ****************************************************************
  // the extended array answers reads from ext_addr in the same cycle, so the
  // address follows the pointer as it stands next cycle; a write keeps the old
  // pointer one more cycle so the registered write lands there and the
  // increment follows it [RQ10] [RQ12]
  // limitation: a data read in the cycle right after a data write is not
  // supported, since both would need the address port in that cycle
  wire [15:0] data_window = ext_rdata;
  wire data_write_hit = data_wr & data_mode;
  wire data_read_hit = data_rd & data_mode;
  reg [15:0] ext_addr_next;
  always @* begin
    ext_addr_next = pointer_next;
    if (data_write_hit) begin
      ext_addr_next = pointer_reg;
    end
  end
  always @(posedge mclk) begin
    if (sys_rst) begin
      ext_addr <= `ZERO16;
      ext_wdata <= `ZERO16;
      ext_write <= 1'b0;
      ext_read <= 1'b0;
    end else begin
      ext_addr <= ext_addr_next;
      ext_wdata <= reg_wdata;
      ext_write <= data_write_hit; // [RQ9] [RQ17]
      ext_read <= data_read_hit;
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  reg [15:0] rd_next;
  always @* begin
    rd_next = `ZERO16;
    if (sel_status) begin
      rd_next = status_value;
    end else if (sel_ctrl) begin
      rd_next[`FUNC_HI:`FUNC_LO] = func_reg; // [RQ16]
      rd_next[`DEVSEL_HI:`DEVSEL_LO] = devsel_reg;
    end else if (sel_data) begin
      if (!dev_ok) begin
        rd_next = `ZERO16; // [RQ13]
      end else if (data_mode) begin
        rd_next = data_window; // [RQ17]
      end else begin
        rd_next = pointer_reg; // [RQ17]
      end
    end else if (sel_cap) begin
      rd_next = `CAPABILITY_VALUE; // [RQ18] [RQ5]
    end
  end

  reg [15:0] rdata_next;
  always @* begin
    rdata_next = reg_rdata;
    if (reg_read) begin
      rdata_next = rd_next;
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= `ZERO16;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      reg_rdata <= rdata_next;
    end
  end
endmodule
`default_nettype wire

// *** testbench/ext_reg_model.sv ***
// extended register array behind the indirect pair
// assumes reads are answered in the same cycle from ext_addr
`timescale 1ns/100ps
`default_nettype none
// ****
// model
// ****
module ext_reg_model (
  input wire mclk,
  input wire [15:0] ext_addr,
  input wire [15:0] ext_wdata,
  input wire ext_write,
  output logic [15:0] ext_rdata
);
  // only 256 words: pointers above 0xFF alias
  logic [15:0] mem [256];
  initial for (int i = 0; i < 256; i++) mem[i] = 16'h5A00 + 16'(i);
  assign ext_rdata = mem[ext_addr[7:0]];
  always @(posedge mclk) if (ext_write) mem[ext_addr[7:0]] <= ext_wdata;
endmodule
`default_nettype wire

// *** testbench/phy_regs_sva.sv ***
// port checker of the management slice
// assumes bind onto the slice, one clock domain
`timescale 1ns/100ps
`default_nettype none
// ****
// checker
// ****
module phy_regs_sva #(parameter IDLE_COUNT_WIDTH = 8) (
  input wire mclk,
  input wire sys_rst,
  input wire [4:0] reg_addr,
  input wire reg_read,
  input wire reg_write,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  input wire ms_master_pin,
  input wire local_rx_ok_pin,
  input wire remote_rx_ok_pin,
  input wire lp_full_pin,
  input wire lp_half_pin,
  input wire [15:0] ext_addr,
  input wire [15:0] ext_wdata,
  input wire ext_write,
  input wire ext_read
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  reg [6:0] ctl_reg;
  wire [4:0] pins = {ms_master_pin, local_rx_ok_pin, remote_rx_ok_pin, lp_full_pin, lp_half_pin};
  wire ok = ctl_reg[4:0] == 5'h1F;
  wire [1:0] fn = ctl_reg[6:5];
  always @(posedge mclk)
    if (sys_rst) ctl_reg <= 7'h00;
    else if (reg_write && reg_addr == 5'h0D) ctl_reg <= {reg_wdata[15:14], reg_wdata[4:0]};
  sequence s_rd(a); reg_read && reg_addr == a; endsequence
  sequence s_dw(f); reg_write && reg_addr == 5'h0E && ok && f; endsequence
  sequence s_dr(f); reg_read && reg_addr == 5'h0E && ok && f; endsequence
  a_cap_fixed: assert property (s_rd(5'h0F) |=> reg_rdata == 16'h3000)
    else $error("capability wrong");
  a_ctl_resv: assert property (s_rd(5'h0D) |=> reg_rdata[13:5] == 9'h000)
    else $error("control reserved set");
  a_sts_bits: assert property ($stable(pins)[*4] ##0 s_rd(5'h0A) |=> reg_rdata[14:8] == {$past(pins), 2'h0})
    else $error("status bits wrong");
  a_dw_pulse: assert property (s_dw(fn != 2'h0) |=> ext_write && ext_wdata == $past(reg_wdata))
    else $error("no extended write");
  a_bad_dev: assert property (reg_write && reg_addr == 5'h0E && !ok |=> !ext_write)
    else $error("ignored access wrote");
  a_ptr_back: assert property (s_dw(fn == 2'h0) ##1 s_dr(fn == 2'h0) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("pointer readback wrong");
  a_ptr_incr: assert property (s_dw(fn[1]) ##1 s_dw(fn[1]) |=> ext_addr == $past(ext_addr) + 16'h0001)
    else $error("pointer not incremented");
  a_ptr_hold: assert property (s_dw(fn == 2'h1) ##1 s_dw(fn == 2'h1) |=> ext_addr == $past(ext_addr))
    else $error("pointer moved");
  a_dr_pulse: assert property (s_dr(fn != 2'h0) |=> ext_read)
    else $error("no extended read");
endmodule
bind phy_status_and_indirect_access_regs phy_regs_sva #(.IDLE_COUNT_WIDTH(IDLE_COUNT_WIDTH)) u_phy_regs_sva (
  .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_read(reg_read), .reg_write(reg_write),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ms_master_pin(ms_master_pin), .local_rx_ok_pin(local_rx_ok_pin),
  .remote_rx_ok_pin(remote_rx_ok_pin), .lp_full_pin(lp_full_pin), .lp_half_pin(lp_half_pin),
  .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_write(ext_write), .ext_read(ext_read));
`default_nettype wire

// *** testbench/phy_status_and_indirect_access_regs_tb.sv ***
// self-checking bench of the management slice
// assumes the extended array model and the bound port checker
`timescale 1ns/100ps
`default_nettype none
// ****
// bench
// ****
module phy_status_and_indirect_access_regs_tb;
  logic mclk = '0, sys_rst = '1, reg_read = '0, reg_write = '0, flt = '0, idl = '0, reg_rvalid, ext_write, ext_read;
  logic [4:0] reg_addr = '0, pins = '0, dev = '0;
  logic [15:0] reg_wdata = '0, reg_rdata, ext_addr, ext_wdata, ext_rdata, ptr = '0;
  logic [15:0] mem [256];
  logic [1:0] fn = '0;
  logic fault = '0;
  int bad_count = 0, samples_checked = 0, cnt = 0, rd_seen = 0, rd_want = 0, q [$];
  always #2 mclk = ~mclk;
  phy_status_and_indirect_access_regs u_phy_status_and_indirect_access_regs (
    .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_read(reg_read), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .ms_fault_pin(flt),
    .ms_master_pin(pins[4]), .local_rx_ok_pin(pins[3]), .remote_rx_ok_pin(pins[2]), .lp_full_pin(pins[1]),
    .lp_half_pin(pins[0]), .idle_error_pin(idl), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_write(ext_write), .ext_read(ext_read), .ext_rdata(ext_rdata));
  ext_reg_model u_ext_reg_model (.mclk(mclk), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_write(ext_write), .ext_rdata(ext_rdata));
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic idle(input int n);
    {reg_read, reg_write} = 2'h0;
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // one bus cycle; the model predicts the read answer before the request goes out
  task automatic acc(input bit w, input logic [4:0] a, input logic [15:0] d);
    logic [15:0] e;
    e = 16'h0000;
    case (a)
      5'h0A: begin
        e = {fault, pins, 2'h0, cnt[7:0]};
        if (!w) {fault, cnt} = '0;
      end
      5'h0D: begin
        e = {fn, 9'h000, dev};
        if (w) {fn, dev} = {d[15:14], d[4:0]};
      end
      5'h0E: if (dev == 5'h1F) begin
        e = fn == 2'h0 ? ptr : mem[ptr[7:0]];
        if (!w && fn != 2'h0) rd_want++;
        if (w && fn == 2'h0) ptr = d;
        else if (w) mem[ptr[7:0]] = d;
        if (fn == 2'h2 || (fn == 2'h3 && w)) ptr++;
      end
      5'h0F: e = 16'h3000;
    endcase
    if (!w) q.push_back(e);
    {reg_write, reg_read, reg_addr, reg_wdata} = {w, !w, a, d};
    @(posedge mclk);
    #1;
  endtask
  task automatic ev(input int n, input bit f);
    repeat (n) begin
      {flt, idl} = {f, !f};
      idle(2);
      {flt, idl} = 2'h0;
      idle(2);
      if (f) fault = 1'b1;
      else if (cnt < 255) cnt++;
    end
  endtask
  always @(posedge mclk) if (reg_rvalid === 1'b1) chk(reg_rdata, 16'(q.pop_front()));
  always @(posedge mclk) if (ext_read === 1'b1) rd_seen++;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'h5A00 + 16'(i);
    void'($urandom(32'hB7FE138F));
    repeat (6) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    for (int a = 8; a < 17; a++) acc(0, 5'(a), 16'h0000);
    acc(1, 5'h0A, 16'hFFFF);
    acc(1, 5'h0F, 16'hFFFF);
    acc(0, 5'h0A, 16'h0000);
    acc(0, 5'h0F, 16'h0000);
    $display("test reset values done");
    repeat (4) begin
      pins = 5'($urandom);
      idle(5);
      acc(0, 5'h0A, 16'h0000);
    end
    $display("test status pins done");
    ev(3, 0);
    ev(1, 1);
    acc(0, 5'h0A, 16'h0000);
    acc(0, 5'h0A, 16'h0000);
    ev(300, 0);
    acc(0, 5'h0A, 16'h0000);
    $display("test latch and counter done");
    for (int f = 1; f < 4; f++)
      for (int k = 0; k < 2; k++) begin
        acc(1, 5'h0D, 16'h3FFF);
        acc(0, 5'h0D, 16'h0000);
        acc(1, 5'h0E, 16'h0020);
        acc(0, 5'h0E, 16'h0000);
        acc(1, 5'h0D, {f[1:0], 14'h001F});
        repeat (2) acc(k == 0, 5'h0E, 16'($urandom));
        acc(1, 5'h0D, 16'h001F);
        acc(0, 5'h0E, 16'h0000);
      end
    acc(1, 5'h0D, 16'h401E);
    acc(1, 5'h0E, 16'hBEEF);
    acc(0, 5'h0E, 16'h0000);
    acc(1, 5'h0D, 16'h401F);
    acc(0, 5'h0E, 16'h0000);
    $display("test indirect access done");
    idle(3);
    chk(16'(q.size()), 16'h0000);
    chk(16'(rd_seen), 16'(rd_want));
    report_and_stop();
  end
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
